// >>> logic/strap_status_consts.svh
// register offsets, field positions, reset values and counts of the strap status bank
// assumes a 16-bit register word and a 16-bit register address
`ifndef STRAP_STATUS_CONSTS_SVH
`define STRAP_STATUS_CONSTS_SVH
`define REG_W                16
`define ADDR_W               16
`define OFS_TEST_CONTROL_MAIN 16'h0016
`define OFS_STRAP_STATUS_ONE 16'h006e
`define OFS_STRAP_STATUS_TWO 16'h006f
`define OFS_TEST_BYTE_COUNT  16'h0071
`define OFS_TEST_CTL_STS_TWO 16'h0072
`define BIT_MIRROR           15
`define BIT_DOWNSHIFT        14
`define BIT_CLK_OUT_OFF      13
`define BIT_REDUCED_MAC_OFF  12
`define BIT_AUTO_XOVER_OFF   10
`define BIT_FORCED_PAIRING   9
`define BIT_HALF_DUPLEX      8
`define BIT_AUTONEG_OFF      7
`define LSB_SPEED_SEL        5
`define LSB_STATION_ADDR     0
`define BIT_FAST_LINK        10
`define LSB_TX_SKEW          4
`define LSB_RX_SKEW          0
`define BIT_WRAP_MODE        4
`define BIT_LOCK             0
`define BIT_LOCK_CLEAR       1
`define BIT_BYTE_OVF         9
`define RST_WRAP_MODE        1'b0
`define RST_BYTE_COUNT       16'h0000
`define STRAP_SETTLE_CYCLES  3'h4
`endif

// >>> logic/strap_status_pkg.sv
// types shared by the strap status bank
// assumes nothing beyond a SystemVerilog package scope
`default_nettype none
package strap_status_pkg;
   typedef enum logic {
      VARIANT_LARGE = 1'b0,
      VARIANT_SMALL = 1'b1
   } variant_t;
   typedef enum logic [1:0] {
      CAP_SETTLE = 2'b00,
      CAP_TAKE   = 2'b01,
      CAP_HOLD   = 2'b10
   } cap_state_t;
   typedef struct packed {
      logic       mirror;
      logic       downshift;
      logic       clk_out_off;
      logic       reduced_mac_off;
      logic       auto_xover_off;
      logic       forced_pairing;
      logic       half_duplex;
      logic       autoneg_off;
      logic [1:0] speed_sel;
      logic [4:0] station_addr;
      logic       fast_link;
      logic [2:0] tx_skew;
      logic [2:0] rx_skew;
   } strap_set_t;
endpackage : strap_status_pkg
`default_nettype wire

// >>> logic/checker_byte_counter.sv
// byte total of the test sequence checker with lock snapshot and saturation
// assumes byte, lock and clear pulses come from logic on clk_i
`timescale 1ns/100ps
`default_nettype none
`include "strap_status_consts.svh"
module checker_byte_counter #(
   parameter int CNT_W = `REG_W
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             byte_i,
   input  wire logic             wrap_mode_i,
   input  wire logic             lock_i,
   input  wire logic             clear_i,
   output logic      [CNT_W-1:0] count_o,
   output logic                  overflow_o
);
   if (CNT_W < 2 || CNT_W > `REG_W) begin : g_bad_width
      $error("counter width out of range");
   end
   logic [CNT_W-1:0] live_reg;
   logic [CNT_W-1:0] live_next;
   logic [CNT_W-1:0] snap_reg;
   logic             ovf_reg;
   wire              at_max   = &live_reg;
   wire              hold_max = at_max & ~wrap_mode_i;
   wire [CNT_W-1:0]  live_inc = hold_max ? live_reg : live_reg + 1'b1;
   wire [CNT_W-1:0]  restart  = byte_i ? CNT_W'(1) : '0;
   assign live_next = clear_i ? restart : (byte_i ? live_inc : live_reg);
   // live count keeps running; software only ever sees the snapshot
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         live_reg <= CNT_W'(`RST_BYTE_COUNT);
         snap_reg <= CNT_W'(`RST_BYTE_COUNT);
         ovf_reg  <= 1'b0;
      end else begin
         live_reg <= live_next;
         if (lock_i | clear_i) begin
            snap_reg <= live_reg;
         end
         ovf_reg <= (byte_i & at_max) | (ovf_reg & ~clear_i);
      end
   end
   assign count_o    = snap_reg;
   assign overflow_o = ovf_reg;
   a_cnt_reset: assert property (@(posedge clk_i)
      sys_rst_i |=> live_reg == '0 && snap_reg == '0)
      else $error("count not zero after reset");
   a_cnt_freeze: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !lock_i && !clear_i |=> $stable(snap_reg))
      else $error("snapshot moved without lock");
   a_cnt_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      lock_i |=> snap_reg == $past(live_reg))
      else $error("lock did not take the live count");
   a_cnt_saturate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !wrap_mode_i && at_max && byte_i && !clear_i |=> &live_reg)
      else $error("count wrapped in saturate mode");
   a_cnt_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      clear_i && !byte_i |=> live_reg == '0 && !ovf_reg)
      else $error("clear did not zero the count");
endmodule : checker_byte_counter
`default_nettype wire

// >>> logic/strap_status_and_prbs_byte_count.sv
// strap status registers and test checker byte count behind a plain register port
// assumes strap pins are asynchronous and settle before reset is released
// Function
// - bit 15 of status one: port mirroring strapped enabled
// - bit 14 of status one: link downshift strapped enabled
// - large variant: bit 13 of status one set when clock output strapped off
// - bit 12 of status one: reduced-pin mac interface strapped off
// - bit 10 of status one: automatic crossover strapped off
// - bit 9 of status one: forced crossed pairing strapped
// - bit 8 of status one: half duplex strapped
// - bit 7 of status one: auto-negotiation strapped off
// - large variant: bits 6:5 of status one give two-bit speed select
// - large variant: bits 4:0 of status one give five-bit station address
// - small variant: bit 5 gives speed select, bit 6 reads zero
// - small variant: bits 3:0 give station address, bit 4 reads zero
// - bit 10 of status two: fast link detect strapped enabled
// - small variant: status two bits 6:4 give transmit skew, else zero
// - small variant: status two bits 2:0 give receive skew, else zero
// - byte count register holds checker byte total, resets to zero
// - byte count frozen for reading on write of lock bits 0 or 1
// - with wrap mode zero the byte count saturates at its maximum
// - writing bit 1 freezes and clears counters, bit 0 only freezes
`timescale 1ns/100ps
`default_nettype none
`include "strap_status_consts.svh"
module strap_status_and_prbs_byte_count #(
   parameter strap_status_pkg::variant_t VARIANT = strap_status_pkg::VARIANT_LARGE,
   parameter int                         CNT_W   = `REG_W
) (
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic [`ADDR_W-1:0] addr_i,
   input  wire logic [`REG_W-1:0]  wr_data_i,
   input  wire logic               wr_en_i,
   input  wire logic               rd_en_i,
   output logic      [`REG_W-1:0]  rd_data_o,
   output logic                    straps_valid_o,
   input  wire logic               mirror_strap_i,
   input  wire logic               downshift_strap_i,
   input  wire logic               clock_output_off_strap_i,
   input  wire logic               reduced_mac_if_off_strap_i,
   input  wire logic               auto_crossover_off_strap_i,
   input  wire logic               forced_pairing_strap_i,
   input  wire logic               half_duplex_strap_i,
   input  wire logic               autoneg_off_strap_i,
   input  wire logic [1:0]         speed_select_strap_wide_i,
   input  wire logic [4:0]         station_address_strap_i,
   input  wire logic               fast_link_detect_strap_i,
   input  wire logic [2:0]         tx_skew_strap_i,
   input  wire logic [2:0]         rx_skew_strap_i,
   input  wire logic               checker_byte_i
);
   localparam int STRAP_W = $bits(strap_status_pkg::strap_set_t);
   localparam bit LARGE   = (VARIANT == strap_status_pkg::VARIANT_LARGE);

   if (CNT_W != `REG_W) begin : g_bad_cnt
      $error("byte count must fill the register word");
   end

   // ---- strap pin synchronisers
   strap_status_pkg::strap_set_t pins;
   assign pins.mirror          = mirror_strap_i;
   assign pins.downshift       = downshift_strap_i;
   assign pins.clk_out_off     = clock_output_off_strap_i;
   assign pins.reduced_mac_off = reduced_mac_if_off_strap_i;
   assign pins.auto_xover_off  = auto_crossover_off_strap_i;
   assign pins.forced_pairing  = forced_pairing_strap_i;
   assign pins.half_duplex     = half_duplex_strap_i;
   assign pins.autoneg_off     = autoneg_off_strap_i;
   assign pins.speed_sel       = speed_select_strap_wide_i;
   assign pins.station_addr    = station_address_strap_i;
   assign pins.fast_link       = fast_link_detect_strap_i;
   assign pins.tx_skew         = tx_skew_strap_i;
   assign pins.rx_skew         = rx_skew_strap_i;

   logic [STRAP_W-1:0] sync1_reg;
   logic [STRAP_W-1:0] sync2_reg;
   logic [STRAP_W-1:0] sync3_reg;
   logic [STRAP_W-1:0] stable_reg;

   // a pin level counts only once stages two and three agree
   for (genvar i = 0; i < STRAP_W; i++) begin : g_sync
      always_ff @(posedge clk_i) begin
         sync1_reg[i] <= pins[i];
         sync2_reg[i] <= sync1_reg[i];
         sync3_reg[i] <= sync2_reg[i];
      end
      wire agree = (sync2_reg[i] == sync3_reg[i]);
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            stable_reg[i] <= 1'b0;
         end else if (agree) begin
            stable_reg[i] <= sync3_reg[i];
         end
      end
   end

   // ---- capture once after reset release
   strap_status_pkg::cap_state_t state_reg;
   strap_status_pkg::cap_state_t state_next;
   logic [2:0]                   settle_reg;
   logic [2:0]                   settle_next;
   strap_status_pkg::strap_set_t held_reg;

   wire settle_done = (settle_reg == `STRAP_SETTLE_CYCLES - 3'h1);
   assign settle_next = (state_reg == strap_status_pkg::CAP_SETTLE) ?
                        settle_reg + 3'h1 : settle_reg;

   always_comb begin
      case (state_reg)
         strap_status_pkg::CAP_SETTLE: begin
            state_next = settle_done ? strap_status_pkg::CAP_TAKE
                                     : strap_status_pkg::CAP_SETTLE;
         end
         strap_status_pkg::CAP_TAKE: begin
            state_next = strap_status_pkg::CAP_HOLD;
         end
         strap_status_pkg::CAP_HOLD: begin
            state_next = strap_status_pkg::CAP_HOLD;
         end
         default: begin
            state_next = strap_status_pkg::CAP_SETTLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg  <= strap_status_pkg::CAP_SETTLE;
         settle_reg <= 3'h0;
      end else begin
         state_reg  <= state_next;
         settle_reg <= settle_next;
      end
   end

   wire take = (state_reg == strap_status_pkg::CAP_TAKE);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         held_reg <= '0;
      end else if (take) begin
         held_reg <= stable_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         straps_valid_o <= 1'b0;
      end else begin
         straps_valid_o <= (state_next == strap_status_pkg::CAP_HOLD);
      end
   end

   // ---- status words; reserved bits stay zero
   logic [`REG_W-1:0] sts1_word;
   logic [`REG_W-1:0] sts2_word;

   always_comb begin
      sts1_word = '0;
      sts1_word[`BIT_MIRROR]          = held_reg.mirror;
      sts1_word[`BIT_DOWNSHIFT]       = held_reg.downshift;
      sts1_word[`BIT_CLK_OUT_OFF]     = LARGE & held_reg.clk_out_off;
      sts1_word[`BIT_REDUCED_MAC_OFF] = held_reg.reduced_mac_off;
      sts1_word[`BIT_AUTO_XOVER_OFF]  = held_reg.auto_xover_off;
      sts1_word[`BIT_FORCED_PAIRING]  = held_reg.forced_pairing;
      sts1_word[`BIT_HALF_DUPLEX]     = held_reg.half_duplex;
      sts1_word[`BIT_AUTONEG_OFF]     = held_reg.autoneg_off;
      if (LARGE) begin
         sts1_word[`LSB_SPEED_SEL +: 2]    = held_reg.speed_sel;
         sts1_word[`LSB_STATION_ADDR +: 5] = held_reg.station_addr;
      end else begin
         sts1_word[`LSB_SPEED_SEL]         = held_reg.speed_sel[0];
         sts1_word[`LSB_STATION_ADDR +: 4] = held_reg.station_addr[3:0];
      end
   end

   always_comb begin
      sts2_word = '0;
      sts2_word[`BIT_FAST_LINK] = held_reg.fast_link;
      if (!LARGE) begin
         sts2_word[`LSB_TX_SKEW +: 3] = held_reg.tx_skew;
         sts2_word[`LSB_RX_SKEW +: 3] = held_reg.rx_skew;
      end
   end

   // ---- register port decode
   wire hit_main = (addr_i == `OFS_TEST_CONTROL_MAIN);
   wire hit_one  = (addr_i == `OFS_STRAP_STATUS_ONE);
   wire hit_two  = (addr_i == `OFS_STRAP_STATUS_TWO);
   wire hit_cnt  = (addr_i == `OFS_TEST_BYTE_COUNT);
   wire hit_ctl2 = (addr_i == `OFS_TEST_CTL_STS_TWO);

   wire wr_ctl2  = wr_en_i & hit_ctl2;
   wire lock_cmd = wr_ctl2 & wr_data_i[`BIT_LOCK];
   wire clr_cmd  = wr_ctl2 & wr_data_i[`BIT_LOCK_CLEAR];

   logic wrap_mode_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wrap_mode_reg <= `RST_WRAP_MODE;
      end else if (wr_en_i & hit_main) begin
         wrap_mode_reg <= wr_data_i[`BIT_WRAP_MODE];
      end
   end

   logic [CNT_W-1:0] byte_total;
   logic             byte_ovf;

   checker_byte_counter #(
      .CNT_W (CNT_W)
   ) u_byte_count (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .byte_i      (checker_byte_i),
      .wrap_mode_i (wrap_mode_reg),
      .lock_i      (lock_cmd),
      .clear_i     (clr_cmd),
      .count_o     (byte_total),
      .overflow_o  (byte_ovf)
   );

   wire [`REG_W-1:0] main_word = `REG_W'(wrap_mode_reg) << `BIT_WRAP_MODE;
   wire [`REG_W-1:0] ctl2_word = `REG_W'(byte_ovf) << `BIT_BYTE_OVF;

   // writes to the status and count words have no target
   wire [`REG_W-1:0] rd_mux =
      hit_one  ? sts1_word  :
      hit_two  ? sts2_word  :
      hit_cnt  ? byte_total :
      hit_main ? main_word  :
      hit_ctl2 ? ctl2_word  : '0;

   wire [`REG_W-1:0] rd_data_next = rd_en_i ? rd_mux : '0;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= rd_data_next;
      end
   end

   // ---- checks
   // a status read is judged one cycle on, once the straps are held
   logic rd_one_reg;
   logic rd_two_reg;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_one_reg <= 1'b0;
         rd_two_reg <= 1'b0;
      end else begin
         rd_one_reg <= rd_en_i & hit_one & straps_valid_o;
         rd_two_reg <= rd_en_i & hit_two & straps_valid_o;
      end
   end

   a_rd_one_fields: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_one_reg |-> rd_data_o[15:14] == {held_reg.mirror, held_reg.downshift}
      && rd_data_o[12] == held_reg.reduced_mac_off
      && rd_data_o[10:7] == {held_reg.auto_xover_off, held_reg.forced_pairing,
                             held_reg.half_duplex, held_reg.autoneg_off})
      else $error("status one flags differ from held straps");
   a_one_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_one_reg |-> !rd_data_o[11] && (LARGE || !rd_data_o[13]))
      else $error("status one reserved bit set");
   a_one_layout: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_one_reg |-> (LARGE ? rd_data_o[6:0] == {held_reg.speed_sel, held_reg.station_addr}
      : rd_data_o[6:0] == {1'b0, held_reg.speed_sel[0], 1'b0,
                           held_reg.station_addr[3:0]}))
      else $error("speed or address field misplaced");
   a_two_layout: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_two_reg |-> rd_data_o[10] == held_reg.fast_link
      && rd_data_o[6:4] == (LARGE ? 3'h0 : held_reg.tx_skew)
      && rd_data_o[2:0] == (LARGE ? 3'h0 : held_reg.rx_skew))
      else $error("status two field wrong");
   a_two_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_two_reg |-> rd_data_o[15:11] == 5'h00 && rd_data_o[9:7] == 3'h0
      && !rd_data_o[3])
      else $error("status two reserved bit set");
   a_held_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_reg == strap_status_pkg::CAP_HOLD |=> $stable(held_reg)
      && state_reg == strap_status_pkg::CAP_HOLD)
      else $error("held straps changed after capture");
   a_capture_bound: assert property (@(posedge clk_i)
      $fell(sys_rst_i) |-> ##[4:6] straps_valid_o)
      else $error("straps not captured in time");
   a_count_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_en_i && hit_cnt |=> rd_data_o == $past(byte_total))
      else $error("byte count read wrong");
   a_read_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !rd_en_i |=> rd_data_o == '0)
      else $error("read data outside read slot");

   // strap capture sequence and writes to read-only words
   a_settle_start: assert property (@(posedge clk_i)
      $fell(sys_rst_i) |-> state_reg == strap_status_pkg::CAP_SETTLE && settle_reg == 3'h0)
      else $error("capture did not start from settle");
   a_held_empty: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      state_reg != strap_status_pkg::CAP_HOLD |-> held_reg == '0)
      else $error("straps held before capture");
   a_take_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      take |=> !take && straps_valid_o)
      else $error("strap capture repeated");
   a_valid_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      straps_valid_o |=> straps_valid_o)
      else $error("strap valid dropped without reset");
   a_status_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      straps_valid_o && wr_en_i && (hit_one || hit_two || hit_cnt)
      |=> $stable(held_reg) && $stable(wrap_mode_reg) && $stable(byte_total))
      else $error("write to a read-only word took effect");

   // control word, decode and reset values
   a_out_reset: assert property (@(posedge clk_i)
      sys_rst_i |=> !straps_valid_o && rd_data_o == '0)
      else $error("outputs not cleared by reset");
   a_count_reset: assert property (@(posedge clk_i)
      sys_rst_i |=> byte_total == '0 && !byte_ovf)
      else $error("count or overflow not cleared by reset");
   a_wrap_reset: assert property (@(posedge clk_i)
      sys_rst_i |=> !wrap_mode_reg)
      else $error("wrap mode not cleared by reset");
   a_wrap_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_en_i && hit_main |=> wrap_mode_reg == $past(wr_data_i[`BIT_WRAP_MODE]))
      else $error("wrap mode write lost");
   a_main_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_en_i && hit_main
      |=> rd_data_o == (`REG_W'($past(wrap_mode_reg)) << `BIT_WRAP_MODE))
      else $error("wrap mode read wrong");
   a_ovf_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_en_i && hit_ctl2
      |=> rd_data_o == (`REG_W'($past(byte_ovf)) << `BIT_BYTE_OVF))
      else $error("overflow flag read wrong");
   a_unmapped_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_en_i && !(hit_one || hit_two || hit_cnt || hit_main || hit_ctl2)
      |=> rd_data_o == '0)
      else $error("unmapped read not zero");

   c_lock_write: cover property (@(posedge clk_i) lock_cmd && !clr_cmd);
   c_clear_write: cover property (@(posedge clk_i) clr_cmd ##[1:2] rd_en_i && hit_cnt);
   c_two_read: cover property (@(posedge clk_i) straps_valid_o && rd_en_i && hit_two);
   c_saturated: cover property (@(posedge clk_i) byte_ovf && !wrap_mode_reg);
   c_strap_read: cover property (@(posedge clk_i) straps_valid_o && rd_en_i && hit_one);
endmodule : strap_status_and_prbs_byte_count
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the strap status bank, both package variants side by side
// assumes the design files and strap_status_consts.svh are compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "strap_status_consts.svh"
module tb;
   localparam int LIMIT = 90000;
   logic              clk_i = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic [15:0]       addr_i = 16'h0000;
   logic [15:0]       wr_data_i = 16'h0000;
   logic              wr_en_i = 1'b0;
   logic              rd_en_i = 1'b0;
   logic              checker_byte_i = 1'b0;
   logic [21:0]       pins = 22'h00_0000;
   logic [15:0]       rd_large;
   logic [15:0]       rd_small;
   logic              valid_large;
   logic              valid_small;
   int                n_errors = 0;
   int                tests_run = 0;
   int                cycles = 0;

   always #2 clk_i = ~clk_i;

   // one pin map feeds both variants so their words can be compared to one pattern
   strap_status_and_prbs_byte_count #(.VARIANT(strap_status_pkg::VARIANT_LARGE)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_large), .straps_valid_o(valid_large),
      .mirror_strap_i(pins[21]), .downshift_strap_i(pins[20]),
      .clock_output_off_strap_i(pins[19]), .reduced_mac_if_off_strap_i(pins[18]),
      .auto_crossover_off_strap_i(pins[17]), .forced_pairing_strap_i(pins[16]),
      .half_duplex_strap_i(pins[15]), .autoneg_off_strap_i(pins[14]),
      .speed_select_strap_wide_i(pins[13:12]), .station_address_strap_i(pins[11:7]),
      .fast_link_detect_strap_i(pins[6]), .tx_skew_strap_i(pins[5:3]),
      .rx_skew_strap_i(pins[2:0]), .checker_byte_i(checker_byte_i));

   strap_status_and_prbs_byte_count #(.VARIANT(strap_status_pkg::VARIANT_SMALL)) dut_small (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_small), .straps_valid_o(valid_small),
      .mirror_strap_i(pins[21]), .downshift_strap_i(pins[20]),
      .clock_output_off_strap_i(pins[19]), .reduced_mac_if_off_strap_i(pins[18]),
      .auto_crossover_off_strap_i(pins[17]), .forced_pairing_strap_i(pins[16]),
      .half_duplex_strap_i(pins[15]), .autoneg_off_strap_i(pins[14]),
      .speed_select_strap_wide_i(pins[13:12]), .station_address_strap_i(pins[11:7]),
      .fast_link_detect_strap_i(pins[6]), .tx_skew_strap_i(pins[5:3]),
      .rx_skew_strap_i(pins[2:0]), .checker_byte_i(checker_byte_i));

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_errors++;
         $display("BAD %0t timeout", $time);
         results();
      end
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk16

   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_en_i   <= 1'b1;
      addr_i    <= a;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_en_i   <= 1'b0;
   endtask : reg_wr

   // data is taken in the single cycle after the strobe
   task automatic reg_rd(input logic [15:0] a, output logic [15:0] dl, output logic [15:0] ds);
      @(posedge clk_i);
      rd_en_i <= 1'b1;
      addr_i  <= a;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1;
      dl = rd_large;
      ds = rd_small;
   endtask : reg_rd

   task automatic bytes(input int n);
      @(posedge clk_i);
      checker_byte_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      checker_byte_i <= 1'b0;
   endtask : bytes

   task automatic do_reset;
      int i;
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (i = 0; i < 20 && !(valid_large === 1'b1 && valid_small === 1'b1); i++) begin
         @(posedge clk_i);
      end
      #1;
      chk16({15'h0000, valid_large & valid_small}, 16'h0001, "straps valid");
   endtask : do_reset

   // capture one pattern, then flip the pins and confirm the words do not follow
   task automatic t_straps(input logic [21:0] p);
      logic [15:0] e1l, e1s, e2l, e2s, dl, ds;
      @(posedge clk_i);
      pins <= p;
      do_reset();
      e1l = {p[21:18], 1'b0, p[17:14], p[13:12], p[11:7]};
      e1s = {p[21:20], 1'b0, p[18], 1'b0, p[17:14], 1'b0, p[12], 1'b0, p[10:7]};
      e2l = {5'h00, p[6], 10'h000};
      e2s = {5'h00, p[6], 3'h0, p[5:3], 1'b0, p[2:0]};
      @(posedge clk_i);
      pins <= ~p;
      repeat (7) @(posedge clk_i);
      reg_rd(`OFS_STRAP_STATUS_ONE, dl, ds);
      chk16(dl, e1l, "status one large");
      chk16(ds, e1s, "status one small");
      reg_rd(`OFS_STRAP_STATUS_TWO, dl, ds);
      chk16(dl, e2l, "status two large");
      chk16(ds, e2s, "status two small");
      reg_wr(`OFS_STRAP_STATUS_ONE, ~e1l);
      reg_wr(`OFS_STRAP_STATUS_TWO, ~e2s);
      reg_rd(`OFS_STRAP_STATUS_ONE, dl, ds);
      chk16(dl, e1l, "status one after write");
      reg_rd(`OFS_STRAP_STATUS_TWO, dl, ds);
      chk16(ds, e2s, "status two after write");
   endtask : t_straps

   task automatic t_misc;
      logic [15:0] dl, ds;
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(dl, `RST_BYTE_COUNT, "count reset value");
      reg_rd(`OFS_TEST_CONTROL_MAIN, dl, ds);
      chk16(dl, 16'h0000, "wrap mode reset");
      reg_wr(`OFS_TEST_CONTROL_MAIN, 16'h0010);
      reg_rd(`OFS_TEST_CONTROL_MAIN, dl, ds);
      chk16(dl, 16'h0010, "wrap mode set");
      reg_wr(`OFS_TEST_CONTROL_MAIN, 16'h0000);
      reg_rd(16'h0070, dl, ds);
      chk16(dl, 16'h0000, "unmapped read");
   endtask : t_misc

   task automatic t_lock;
      logic [15:0] dl, ds;
      bytes(5);
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0001);
      bytes(3);
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(dl, 16'h0005, "lock snapshot");
      reg_wr(`OFS_TEST_BYTE_COUNT, 16'h1234);
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(dl, 16'h0005, "write to count ignored");
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0002);
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(ds, 16'h0008, "lock and clear snapshot");
      bytes(2);
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0001);
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(dl, 16'h0002, "count restarted after clear");
   endtask : t_lock

   // with wrap mode off the total sticks at its maximum and flags overflow
   task automatic t_saturate;
      logic [15:0] dl, ds;
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0002);
      bytes(65537);
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0001);
      reg_rd(`OFS_TEST_BYTE_COUNT, dl, ds);
      chk16(dl, 16'hffff, "saturated count");
      reg_rd(`OFS_TEST_CTL_STS_TWO, dl, ds);
      chk16(dl, 16'h0200, "overflow flag");
      reg_wr(`OFS_TEST_CTL_STS_TWO, 16'h0002);
      reg_rd(`OFS_TEST_CTL_STS_TWO, dl, ds);
      chk16(dl, 16'h0000, "overflow cleared");
   endtask : t_saturate

   initial begin
      t_straps(22'h3f_ffff);
      t_misc();
      t_straps(22'h00_0000);
      t_straps(22'h2a_d5ab);
      t_lock();
      t_saturate();
      results();
   end
endmodule : tb
`default_nettype wire
